// file: logic/vic_pkg.sv
// vectored interrupt controller: shared constants and types
`default_nettype none
package vic_pkg;
   // ==========================================================
   // register byte addresses on the bus
   // ==========================================================
   localparam logic [7:0] ADDR_REQ1 = 8'h00; // pending requests, group one
   localparam logic [7:0] ADDR_REQ2 = 8'h04; // pending requests, group two
   localparam logic [7:0] ADDR_ENA1 = 8'h08; // enables, group one
   localparam logic [7:0] ADDR_ENA2 = 8'h0C; // enables, group two
   localparam logic [7:0] ADDR_POL = 8'h10; // pin polarity and source select
   localparam logic [7:0] ADDR_SEL = 8'h14; // sprite / timer-four select
   localparam logic [7:0] ADDR_STAT = 8'h18; // flag and last vector
   // ==========================================================
   // field positions
   // ==========================================================
   // group one: timer1..4, overlay, vsync, conv/pin
   localparam int BIT_TM1 = 0;
   localparam int BIT_TM2 = 1;
   localparam int BIT_TM3 = 2;
   localparam int BIT_TM4 = 3;
   localparam int BIT_OVL = 4;
   localparam int BIT_VSY = 5;
   localparam int BIT_ADC = 6;
   // group two: pin a, slicer, serial, tick, pin b, two-wire, timer56
   localparam int BIT_PA = 0;
   localparam int BIT_DSL = 1;
   localparam int BIT_SIO = 2;
   localparam int BIT_TCK = 3;
   localparam int BIT_PB = 4;
   localparam int BIT_TWB = 5;
   localparam int BIT_T56 = 6;
   localparam int BIT_TPS = 7; // timer_pair_select in enable group two
   // polarity register
   localparam int BIT_POLA = 3;
   localparam int BIT_POLB = 4;
   localparam int BIT_POLC = 6;
   localparam int BIT_CPS = 7; // conv_or_pin_select
   localparam int BIT_SPS = 0; // sprite select in select register
   // ==========================================================
   // reset values
   // ==========================================================
   localparam logic [6:0] RST_REQ = 7'h00;
   localparam logic [7:0] RST_ENA2 = 8'h00;
   localparam logic [6:0] RST_ENA1 = 7'h00;
   localparam logic [7:0] RST_POL = 8'h00;
   localparam logic RST_IFLAG = 1'b1;
   // ==========================================================
   // vectors (low byte address of each pair)
   // ==========================================================
   localparam logic [15:0] VEC_RESET = 16'hFFFE;
   localparam logic [15:0] VEC_OVL = 16'hFFFC;
   localparam logic [15:0] VEC_PA = 16'hFFFA;
   localparam logic [15:0] VEC_DSL = 16'hFFF8;
   localparam logic [15:0] VEC_SIO = 16'hFFF6;
   localparam logic [15:0] VEC_T4S = 16'hFFF4;
   localparam logic [15:0] VEC_TCK = 16'hFFF2;
   localparam logic [15:0] VEC_VSY = 16'hFFF0;
   localparam logic [15:0] VEC_TM3 = 16'hFFEE;
   localparam logic [15:0] VEC_TM2 = 16'hFFEC;
   localparam logic [15:0] VEC_TM1 = 16'hFFEA;
   localparam logic [15:0] VEC_ADC = 16'hFFE8;
   localparam logic [15:0] VEC_PB = 16'hFFE6;
   localparam logic [15:0] VEC_TWB = 16'hFFE4;
   localparam logic [15:0] VEC_T56 = 16'hFFE2;
   localparam logic [15:0] VEC_BRK = 16'hFFDE;
   localparam int NSRC = 14; // maskable vectored sources
   // ==========================================================
   // acceptance sequencer
   // ==========================================================
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_PUSH_PCH = 3'b001,
      ST_PUSH_PCL = 3'b010,
      ST_PUSH_PS = 3'b011,
      ST_FETCH_LO = 3'b100,
      ST_FETCH_HI = 3'b101,
      ST_LOAD = 3'b110
   } vic_state_t;
endpackage
`default_nettype wire

// file: logic/vic_edge_det.sv
// selectable-polarity edge detector for one external request pin
`default_nettype none
module vic_edge_det (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic pin,
   input wire logic falling,
   output logic hit
);
   // ==========================================================
   // previous level
   // ==========================================================
   logic prev_q; // level seen last cycle
   logic prev_d;
   always_comb begin
      prev_d = pin;
   end
   // reset to zero so a pin high at reset reads as a rising edge in the first cycle after reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= prev_d;
      end
   end
   // edge of the chosen direction
   always_comb begin
      hit = falling ? (prev_q & ~pin) : (~prev_q & pin);
   end
endmodule
`default_nettype wire

// file: logic/vic_top.sv
// vectored interrupt controller with AHB-Lite register slave and core handshake
// Operation
// - nineteen sources: three pins, fourteen events, break, reset
// - accept pushes program counter and flags
// - accept sets mask flag, clears request
// - then load counter from source vector
// - mask flag one blocks maskable acceptance
// - each non-break source owns request/enable bit
// - accept needs enable, request, flag zero
// - write zero clears request; one ignored
// - enable bits freely writable
// - reset is top-priority non-maskable, top vector
// - fixed priority, own vector pair each
// - timer-four/sprite source at priority six
// - conv/pin-c shared at twelve, edge programmable
// - two-wire bus at priority fourteen
// - timer five/six shared at fifteen, switchable
// - reset loads high byte top, low below
// - break lowest, no enable, ignores flag
// - pair select zero timer5, one timer6
// - select zero pin c, one converter
//
// The AHB-Lite register port and the register addresses were decided locally.
`default_nettype none
module vic_top (
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // request sources
   input wire logic ext_pin_irq_a,
   input wire logic ext_pin_irq_b,
   input wire logic ext_pin_irq_c,
   input wire logic [3:0] tmr_ovf, // timers one to four, one-cycle pulses
   input wire logic tmr5_ovf,
   input wire logic tmr6_ovf,
   input wire logic screen_overlay_done,
   input wire logic vsync_evt,
   input wire logic conv_done,
   input wire logic slicer_done,
   input wire logic serial_done,
   input wire logic sprite_done,
   input wire logic tick_evt,
   input wire logic twowire_evt,
   input wire logic soft_break_instr, // core decodes the break opcode
   // core side
   input wire logic [15:0] core_pc, // current program counter
   input wire logic [7:0] proc_flags_reg, // current status flags
   input wire logic core_at_boundary, // core may be interrupted now
   input wire logic [7:0] mem_rdata, // vector byte read back
   input wire logic mem_ack, // bus cycle for push or fetch done
   output logic core_hold, // core stalled while sequencing
   output logic mem_req,
   output logic mem_write,
   output logic mem_stack, // push goes to stack, fetch to vector
   output logic [15:0] mem_addr, // vector address during fetches
   output logic [7:0] mem_wdata,
   output logic pc_load,
   output logic [7:0] pc_high_byte,
   output logic [7:0] pc_low_byte,
   output logic int_mask_flag
);
   // ==========================================================
   // edge detectors on the three pins
   // ==========================================================
   logic [7:0] pol_q; // polarity and source select
   logic [7:0] pol_d;
   logic hit_a;
   logic hit_b;
   logic hit_c;
   vic_edge_det u_edge_a (
      .hclk(hclk),
      .hresetn(hresetn),
      .pin(ext_pin_irq_a),
      .falling(pol_q[vic_pkg::BIT_POLA]),
      .hit(hit_a)
   );
   vic_edge_det u_edge_b (
      .hclk(hclk),
      .hresetn(hresetn),
      .pin(ext_pin_irq_b),
      .falling(pol_q[vic_pkg::BIT_POLB]),
      .hit(hit_b)
   );
   vic_edge_det u_edge_c (
      .hclk(hclk),
      .hresetn(hresetn),
      .pin(ext_pin_irq_c),
      .falling(pol_q[vic_pkg::BIT_POLC]),
      .hit(hit_c)
   );
   // ==========================================================
   // bus address phase capture
   // ==========================================================
   logic wr_pend_q; // write data phase pending
   logic [7:0] wr_addr_q;
   logic wr_pend_d;
   logic [7:0] wr_addr_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic take;
   logic [6:0] req1_q; // pending requests
   logic [6:0] req2_q;
   logic [6:0] req1_d;
   logic [6:0] req2_d;
   logic [6:0] ena1_q; // enables
   logic [7:0] ena2_q;
   logic [6:0] ena1_d;
   logic [7:0] ena2_d;
   logic sel_q; // sprite versus timer-four select
   logic sel_d;
   logic iflag_q;
   logic iflag_d;
   logic [15:0] last_vec_q;
   logic [15:0] last_vec_d;
   always_comb begin
      take = hsel & hready & htrans[1];
      wr_pend_d = take & hwrite;
      wr_addr_d = take ? haddr : wr_addr_q;
      rdata_d = 32'h0000_0000;
      // reads answer in the data phase with zero wait
      if (take && !hwrite) begin
         case (haddr)
            vic_pkg::ADDR_REQ1: rdata_d = {25'h000_0000, req1_q};
            vic_pkg::ADDR_REQ2: rdata_d = {25'h000_0000, req2_q};
            vic_pkg::ADDR_ENA1: rdata_d = {25'h000_0000, ena1_q};
            vic_pkg::ADDR_ENA2: rdata_d = {24'h00_0000, ena2_q};
            vic_pkg::ADDR_POL: rdata_d = {24'h00_0000, pol_q};
            vic_pkg::ADDR_SEL: rdata_d = {31'h0000_0000, sel_q};
            vic_pkg::ADDR_STAT: rdata_d = {15'h0000, iflag_q, last_vec_q};
            default: rdata_d = 32'h0000_0000; // unmapped reads zero
         endcase
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         rdata_q <= 32'h0000_0000;
      end else begin
         wr_pend_q <= wr_pend_d;
         wr_addr_q <= wr_addr_d;
         rdata_q <= rdata_d;
      end
   end
   always_comb begin
      hrdata = rdata_q;
      hreadyout = 1'b1; // never waits
      hresp = 1'b0; // always OKAY
   end
   // ==========================================================
   // shared-source muxing and raw events
   // ==========================================================
   logic [6:0] ev1;
   logic [6:0] ev2;
   always_comb begin
      ev1 = 7'h00;
      ev2 = 7'h00;
      ev1[vic_pkg::BIT_TM1] = tmr_ovf[0];
      ev1[vic_pkg::BIT_TM2] = tmr_ovf[1];
      ev1[vic_pkg::BIT_TM3] = tmr_ovf[2];
      // sprite completion shares the timer-four slot
      ev1[vic_pkg::BIT_TM4] = sel_q ? sprite_done : tmr_ovf[3];
      ev1[vic_pkg::BIT_OVL] = screen_overlay_done;
      ev1[vic_pkg::BIT_VSY] = vsync_evt;
      // shared slot: zero pin c, one converter
      ev1[vic_pkg::BIT_ADC] = pol_q[vic_pkg::BIT_CPS] ? conv_done : hit_c;
      ev2[vic_pkg::BIT_PA] = hit_a;
      ev2[vic_pkg::BIT_DSL] = slicer_done;
      ev2[vic_pkg::BIT_SIO] = serial_done;
      ev2[vic_pkg::BIT_TCK] = tick_evt;
      ev2[vic_pkg::BIT_PB] = hit_b;
      ev2[vic_pkg::BIT_TWB] = twowire_evt;
      // zero timer five, one timer six
      ev2[vic_pkg::BIT_T56] = ena2_q[vic_pkg::BIT_TPS] ? tmr6_ovf : tmr5_ovf;
   end
   // ==========================================================
   // priority resolve, highest first
   // ==========================================================
   logic [vic_pkg::NSRC-1:0] elig; // index 0 = priority two
   logic [vic_pkg::NSRC-1:0] pend;
   logic any_elig;
   logic [3:0] win_idx;
   logic [15:0] win_vec;
   always_comb begin
      pend = {req2_q[vic_pkg::BIT_T56], req2_q[vic_pkg::BIT_TWB], req2_q[vic_pkg::BIT_PB],
              req1_q[vic_pkg::BIT_ADC], req1_q[vic_pkg::BIT_TM1], req1_q[vic_pkg::BIT_TM2],
              req1_q[vic_pkg::BIT_TM3], req1_q[vic_pkg::BIT_VSY], req2_q[vic_pkg::BIT_TCK],
              req1_q[vic_pkg::BIT_TM4], req2_q[vic_pkg::BIT_SIO], req2_q[vic_pkg::BIT_DSL],
              req2_q[vic_pkg::BIT_PA], req1_q[vic_pkg::BIT_OVL]};
      elig = pend & {ena2_q[vic_pkg::BIT_T56], ena2_q[vic_pkg::BIT_TWB],
                     ena2_q[vic_pkg::BIT_PB], ena1_q[vic_pkg::BIT_ADC],
                     ena1_q[vic_pkg::BIT_TM1], ena1_q[vic_pkg::BIT_TM2],
                     ena1_q[vic_pkg::BIT_TM3], ena1_q[vic_pkg::BIT_VSY],
                     ena2_q[vic_pkg::BIT_TCK], ena1_q[vic_pkg::BIT_TM4],
                     ena2_q[vic_pkg::BIT_SIO], ena2_q[vic_pkg::BIT_DSL],
                     ena2_q[vic_pkg::BIT_PA], ena1_q[vic_pkg::BIT_OVL]};
      any_elig = (|elig) & ~iflag_q;
      win_idx = 4'h0;
      // scan from lowest priority upward so the highest wins
      for (int i = vic_pkg::NSRC - 1; i >= 0; i--) begin
         if (elig[i]) begin
            win_idx = 4'(i);
         end
      end
      case (win_idx)
         4'h0: win_vec = vic_pkg::VEC_OVL;
         4'h1: win_vec = vic_pkg::VEC_PA;
         4'h2: win_vec = vic_pkg::VEC_DSL;
         4'h3: win_vec = vic_pkg::VEC_SIO;
         4'h4: win_vec = vic_pkg::VEC_T4S;
         4'h5: win_vec = vic_pkg::VEC_TCK;
         4'h6: win_vec = vic_pkg::VEC_VSY;
         4'h7: win_vec = vic_pkg::VEC_TM3;
         4'h8: win_vec = vic_pkg::VEC_TM2;
         4'h9: win_vec = vic_pkg::VEC_TM1;
         4'hA: win_vec = vic_pkg::VEC_ADC;
         4'hB: win_vec = vic_pkg::VEC_PB;
         4'hC: win_vec = vic_pkg::VEC_TWB;
         4'hD: win_vec = vic_pkg::VEC_T56;
         default: win_vec = vic_pkg::VEC_BRK;
      endcase
   end
   // ==========================================================
   // acceptance sequencer
   // ==========================================================
   vic_pkg::vic_state_t st_q;
   vic_pkg::vic_state_t st_d;
   logic [15:0] vec_q; // vector being fetched
   logic [15:0] vec_d;
   logic [7:0] lo_q; // low byte fetched first
   logic [7:0] lo_d;
   logic [7:0] hi_q;
   logic [7:0] hi_d;
   logic start_irq;
   logic start_brk;
   logic [13:0] clr_onehot;
   logic boot_q; // reset fetch still owed
   logic boot_d;
   always_comb begin
      start_irq = (st_q == vic_pkg::ST_IDLE) & core_at_boundary & any_elig & ~boot_q;
      // break ignores the mask and no enable gates it; loses to any eligible source
      start_brk = (st_q == vic_pkg::ST_IDLE) & ~boot_q & soft_break_instr
                  & ~any_elig;
      clr_onehot = start_irq ? (14'h0001 << win_idx) : 14'h0000;
      st_d = st_q;
      vec_d = vec_q;
      lo_d = lo_q;
      hi_d = hi_q;
      boot_d = boot_q;
      iflag_d = iflag_q;
      last_vec_d = last_vec_q;
      case (st_q)
         vic_pkg::ST_IDLE: begin
            if (boot_q) begin
               // reset behaves as top-priority non-maskable entry, no push
               vec_d = vic_pkg::VEC_RESET;
               st_d = vic_pkg::ST_FETCH_LO;
            end else if (start_irq || start_brk) begin
               vec_d = start_irq ? win_vec : vic_pkg::VEC_BRK;
               iflag_d = 1'b1;
               st_d = vic_pkg::ST_PUSH_PCH;
            end
         end
         vic_pkg::ST_PUSH_PCH: if (mem_ack) st_d = vic_pkg::ST_PUSH_PCL;
         vic_pkg::ST_PUSH_PCL: if (mem_ack) st_d = vic_pkg::ST_PUSH_PS;
         vic_pkg::ST_PUSH_PS: if (mem_ack) st_d = vic_pkg::ST_FETCH_LO;
         vic_pkg::ST_FETCH_LO: begin
            if (mem_ack) begin
               lo_d = mem_rdata;
               st_d = vic_pkg::ST_FETCH_HI;
            end
         end
         vic_pkg::ST_FETCH_HI: begin
            if (mem_ack) begin
               hi_d = mem_rdata; // high byte from the upper address
               st_d = vic_pkg::ST_LOAD;
            end
         end
         vic_pkg::ST_LOAD: begin
            boot_d = 1'b0;
            last_vec_d = vec_q;
            st_d = vic_pkg::ST_IDLE;
         end
         default: st_d = vic_pkg::ST_IDLE;
      endcase
      // software may rewrite the mask through the status register
      if (wr_pend_q && wr_addr_q == vic_pkg::ADDR_STAT) begin
         iflag_d = hwdata[16];
      end
      if (st_q == vic_pkg::ST_IDLE && (start_irq || start_brk)) begin
         iflag_d = 1'b1; // accept wins over a software clear
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= vic_pkg::ST_IDLE;
         vec_q <= 16'h0000;
         lo_q <= 8'h00;
         hi_q <= 8'h00;
         boot_q <= 1'b1;
         iflag_q <= vic_pkg::RST_IFLAG;
         last_vec_q <= 16'h0000;
      end else begin
         st_q <= st_d;
         vec_q <= vec_d;
         lo_q <= lo_d;
         hi_q <= hi_d;
         boot_q <= boot_d;
         iflag_q <= iflag_d;
         last_vec_q <= last_vec_d;
      end
   end
   // core handshake outputs
   always_comb begin
      core_hold = (st_q != vic_pkg::ST_IDLE) | boot_q;
      mem_req = (st_q != vic_pkg::ST_IDLE) & (st_q != vic_pkg::ST_LOAD);
      mem_write = (st_q == vic_pkg::ST_PUSH_PCH) | (st_q == vic_pkg::ST_PUSH_PCL)
                  | (st_q == vic_pkg::ST_PUSH_PS);
      mem_stack = mem_write;
      mem_addr = (st_q == vic_pkg::ST_FETCH_HI) ? (vec_q | 16'h0001) : vec_q;
      case (st_q)
         vic_pkg::ST_PUSH_PCH: mem_wdata = core_pc[15:8];
         vic_pkg::ST_PUSH_PCL: mem_wdata = core_pc[7:0];
         vic_pkg::ST_PUSH_PS: mem_wdata = proc_flags_reg;
         default: mem_wdata = 8'h00;
      endcase
      pc_load = (st_q == vic_pkg::ST_LOAD);
      pc_high_byte = hi_q;
      pc_low_byte = lo_q;
      int_mask_flag = iflag_q;
   end
   // ==========================================================
   // request, enable and select registers
   // ==========================================================
   always_comb begin
      req1_d = req1_q;
      req2_d = req2_q;
      ena1_d = ena1_q;
      ena2_d = ena2_q;
      pol_d = pol_q;
      sel_d = sel_q;
      if (wr_pend_q) begin
         case (wr_addr_q)
            vic_pkg::ADDR_REQ1: req1_d = req1_q & hwdata[6:0]; // zero clears, one
            vic_pkg::ADDR_REQ2: req2_d = req2_q & hwdata[6:0];
            vic_pkg::ADDR_ENA1: ena1_d = hwdata[6:0];
            vic_pkg::ADDR_ENA2: ena2_d = hwdata[7:0];
            vic_pkg::ADDR_POL: pol_d = hwdata[7:0] & 8'hD8;
            vic_pkg::ADDR_SEL: sel_d = hwdata[vic_pkg::BIT_SPS];
            default: ;
         endcase
      end
      // clear of the accepted source, remapped to register bits
      req1_d[vic_pkg::BIT_OVL] = req1_d[vic_pkg::BIT_OVL] & ~clr_onehot[0];
      req2_d[vic_pkg::BIT_PA] = req2_d[vic_pkg::BIT_PA] & ~clr_onehot[1];
      req2_d[vic_pkg::BIT_DSL] = req2_d[vic_pkg::BIT_DSL] & ~clr_onehot[2];
      req2_d[vic_pkg::BIT_SIO] = req2_d[vic_pkg::BIT_SIO] & ~clr_onehot[3];
      req1_d[vic_pkg::BIT_TM4] = req1_d[vic_pkg::BIT_TM4] & ~clr_onehot[4];
      req2_d[vic_pkg::BIT_TCK] = req2_d[vic_pkg::BIT_TCK] & ~clr_onehot[5];
      req1_d[vic_pkg::BIT_VSY] = req1_d[vic_pkg::BIT_VSY] & ~clr_onehot[6];
      req1_d[vic_pkg::BIT_TM3] = req1_d[vic_pkg::BIT_TM3] & ~clr_onehot[7];
      req1_d[vic_pkg::BIT_TM2] = req1_d[vic_pkg::BIT_TM2] & ~clr_onehot[8];
      req1_d[vic_pkg::BIT_TM1] = req1_d[vic_pkg::BIT_TM1] & ~clr_onehot[9];
      req1_d[vic_pkg::BIT_ADC] = req1_d[vic_pkg::BIT_ADC] & ~clr_onehot[10];
      req2_d[vic_pkg::BIT_PB] = req2_d[vic_pkg::BIT_PB] & ~clr_onehot[11];
      req2_d[vic_pkg::BIT_TWB] = req2_d[vic_pkg::BIT_TWB] & ~clr_onehot[12];
      req2_d[vic_pkg::BIT_T56] = req2_d[vic_pkg::BIT_T56] & ~clr_onehot[13];
      // new events set last so they beat any clear in the same cycle
      req1_d = req1_d | ev1;
      req2_d = req2_d | ev2;
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         req1_q <= vic_pkg::RST_REQ;
         req2_q <= vic_pkg::RST_REQ;
         ena1_q <= vic_pkg::RST_ENA1;
         ena2_q <= vic_pkg::RST_ENA2;
         pol_q <= vic_pkg::RST_POL;
         sel_q <= 1'b0;
      end else begin
         req1_q <= req1_d;
         req2_q <= req2_d;
         ena1_q <= ena1_d;
         ena2_q <= ena2_d;
         pol_q <= pol_d;
         sel_q <= sel_d;
      end
   end
endmodule
`default_nettype wire

// file: test/vic_checker.sv
// checker for the acceptance handshake of vic_top
`default_nettype none
module vic_checker (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic core_hold,
   input wire logic int_mask_flag,
   input wire logic mem_req,
   input wire logic mem_write,
   input wire logic mem_stack,
   input wire logic [15:0] mem_addr,
   input wire logic [7:0] mem_wdata,
   input wire logic mem_ack,
   input wire logic [7:0] mem_rdata,
   input wire logic pc_load,
   input wire logic [7:0] pc_high_byte,
   input wire logic [15:0] core_pc,
   input wire logic soft_break_instr,
   input wire logic core_at_boundary
);
   timeunit 1ns / 1ns;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // ==========================================
   // answered vector fetch beats, low and high byte
   sequence lo_s; mem_req && mem_ack && !mem_write && !mem_addr[0]; endsequence
   sequence hi_s; mem_req && mem_ack && !mem_write && mem_addr[0]; endsequence
   accept_mask_a: assert property ($rose(core_hold) |-> int_mask_flag)
      else $error("accept left mask flag clear");
   push_first_a: assert property ($rose(core_hold) |-> mem_stack &&
      mem_req && mem_write && mem_wdata == core_pc[15:8]) else $error("first push wrong");
   fetch_pair_a: assert property (lo_s |=> mem_req && !mem_write &&
      mem_addr == ($past(mem_addr) | 16'h0001)) else $error("high vector byte not next");
   load_high_a: assert property (hi_s |=> pc_load && pc_high_byte == $past(mem_rdata))
      else $error("counter not loaded from vector");
   reset_vec_a: assert property ($rose(hresetn) |->
      ##[0:2] mem_req && !mem_write && mem_addr == 16'hFFFE) else $error("no reset fetch");
   reset_flag_a: assert property ($rose(hresetn) |-> int_mask_flag)
      else $error("mask flag clear after reset");
   masked_idle_a: assert property (int_mask_flag && !core_hold && !soft_break_instr
      |=> !core_hold) else $error("accepted while masked");
   break_free_a: assert property (soft_break_instr && int_mask_flag && !core_hold
      && core_at_boundary |=> core_hold) else $error("break not taken");
endmodule
bind vic_top vic_checker i_vic_checker (.hclk, .hresetn, .core_hold, .int_mask_flag, .mem_req,
   .mem_write, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .pc_load, .pc_high_byte, .core_pc,
   .soft_break_instr, .core_at_boundary, .mem_stack);
`default_nettype wire

// file: test/vic_core_model.sv
// memory side of the core: answers pushes and vector fetches
`default_nettype none
module vic_core_model (
   input wire logic hclk,
   input wire logic mem_req,
   input wire logic [15:0] mem_addr,
   output logic mem_ack = 1'b0,
   output logic [7:0] mem_rdata = 8'h00
);
   timeunit 1ns / 1ns;
   integer seed = 42;
   logic go;
   // ==========================================
   // random stalls; data is addr xor A5 on ack, toggling otherwise
   always @(posedge hclk) begin
      go = mem_req && !mem_ack && ($random(seed) % 2 != 0);
      mem_ack <= go;
      mem_rdata <= go ? (mem_addr[7:0] ^ 8'hA5) : ~mem_rdata;
   end
endmodule
`default_nettype wire

// file: test/tb_top.sv
// self-checking bench for the vectored interrupt controller
`default_nettype none
module tb_top;
   timeunit 1ns / 1ns;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, soft_break_instr = 1'b0;
   logic core_at_boundary = 1'b0, hreadyout, hresp, core_hold, mem_req, mem_write, mem_stack;
   logic mem_ack, pc_load, int_mask_flag;
   logic [1:0] htrans = 2'b00;
   logic [7:0] haddr = 8'h00, proc_flags_reg = 8'h00, v, mem_rdata, mem_wdata;
   logic [7:0] pc_high_byte, pc_low_byte;
   logic [15:0] core_pc = 16'h0000, mem_addr, exp_q[$];
   logic [16:0] ev = 17'h00000; // one bit per source, priority order in [13:0]
   logic [31:0] hwdata = 32'h0, hrdata, d;
   integer seed = 42;
   int err_count = 0, n_compared = 0;
   vic_top i_vic_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .ext_pin_irq_a(ev[1]),
      .ext_pin_irq_b(ev[11]), .ext_pin_irq_c(ev[16]), .tmr_ovf({ev[4], ev[7], ev[8], ev[9]}),
      .tmr5_ovf(ev[13]), .tmr6_ovf(ev[14]), .screen_overlay_done(ev[0]), .vsync_evt(ev[6]),
      .conv_done(ev[10]), .slicer_done(ev[2]), .serial_done(ev[3]), .sprite_done(ev[15]),
      .tick_evt(ev[5]), .twowire_evt(ev[12]), .soft_break_instr, .core_pc, .proc_flags_reg,
      .core_at_boundary, .mem_rdata, .mem_ack, .core_hold, .mem_req, .mem_write, .mem_stack,
      .mem_addr, .mem_wdata, .pc_load, .pc_high_byte, .pc_low_byte, .int_mask_flag);
   vic_core_model i_vic_core_model (.hclk, .mem_req, .mem_addr, .mem_ack, .mem_rdata);
   initial forever #10 hclk = ~hclk;
   // core interruptible on most cycles only, so acceptance timing varies
   always @(posedge hclk) core_at_boundary <= ($random(seed) % 4 != 0);
   // ==========================================
   // tasks
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one single transfer; for reads dt is the expected word
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] dt);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= dt;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      if (!w) cmp(hrdata, dt);
   endtask
   task automatic pulse(input logic [16:0] m);
      ev <= m;
      repeat (2) @(posedge hclk);
      ev <= 17'h00000;
      repeat (3) @(posedge hclk);
   endtask
   // waits out one acceptance; break is dropped once it was taken
   task automatic serve();
      for (int k = 0; k < 300 && core_hold !== 1'b1; k++) @(posedge hclk);
      soft_break_instr <= 1'b0;
      for (int k = 0; k < 300 && core_hold !== 1'b0; k++) @(posedge hclk);
   endtask
   // select a shared source: the other one must not raise the request
   task automatic alt(input logic [7:0] a, input logic [31:0] dt, input logic [16:0] bad,
                      input logic [16:0] good, input logic [7:0] ra, input logic [31:0] rv);
      bus(1'b1, a, dt);
      pulse(bad);
      bus(1'b0, ra, 32'h0);
      pulse(good);
      bus(1'b0, ra, rv);
      bus(1'b1, ra, 32'hFFFFFFFF);
      bus(1'b0, ra, rv);
      bus(1'b1, ra, 32'h0);
      bus(1'b0, ra, 32'h0);
   endtask
   task automatic complete_run();
      $display("errors %0d, compared %0d", err_count, n_compared);
      if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // every counter load takes the oldest noted target
   always @(posedge hclk) if (pc_load === 1'b1)
      cmp({16'h0, pc_high_byte, pc_low_byte}, {16'h0, exp_q.pop_front()});
   initial begin
      repeat (20000) @(posedge hclk);
      err_count++;
      complete_run();
   end
   // ==========================================
   // main sequence
   initial begin
      {core_pc, proc_flags_reg} <= 24'($random(seed));
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      exp_q.push_back(16'h5A5B);
      for (int a = 0; a <= 16; a += 4) bus(1'b0, 8'(a), 32'h0);
      bus(1'b1, 8'h40, 32'hFFFFFFFF);
      bus(1'b0, 8'h40, 32'h0);
      d = $random(seed);
      bus(1'b1, vic_pkg::ADDR_ENA1, d);
      bus(1'b0, vic_pkg::ADDR_ENA1, {25'h0, d[6:0]});
      serve();
      bus(1'b1, vic_pkg::ADDR_ENA1, 32'h7F);
      bus(1'b1, vic_pkg::ADDR_ENA2, 32'h7F);
      bus(1'b1, vic_pkg::ADDR_POL, 32'h80);
      pulse(17'h03FFF);
      bus(1'b0, vic_pkg::ADDR_REQ1, 32'h7F);
      bus(1'b0, vic_pkg::ADDR_REQ2, 32'h7F);
      // clearing the flag lets exactly the highest pending source in
      for (int i = 0; i < 14; i++) begin
         v = 8'hFC - 8'(2 * i);
         exp_q.push_back({v ^ 8'hA4, v ^ 8'hA5});
         bus(1'b1, vic_pkg::ADDR_STAT, 32'h0);
         serve();
      end
      bus(1'b0, vic_pkg::ADDR_REQ1, 32'h0);
      bus(1'b0, vic_pkg::ADDR_REQ2, 32'h0);
      alt(vic_pkg::ADDR_ENA2, 32'hFF, 17'h02000, 17'h04000, vic_pkg::ADDR_REQ2, 32'h40);
      alt(vic_pkg::ADDR_POL, 32'h40, 17'h00400, 17'h10000, vic_pkg::ADDR_REQ1, 32'h40);
      alt(vic_pkg::ADDR_SEL, 32'h1, 17'h00010, 17'h08000, vic_pkg::ADDR_REQ1, 32'h08);
      exp_q.push_back(16'h7A7B);
      soft_break_instr <= 1'b1;
      serve();
      cmp(32'(exp_q.size()), 32'h0);
      bus(1'b0, vic_pkg::ADDR_STAT, 32'h0001FFDE);
      complete_run();
   end
endmodule
`default_nettype wire
